// [inc/dgp_pkg.sv]
// Purpose: shared constants and types for the dual GPIO port block
// Assumes: 8-bit register port, single core clock
// Notes:   offsets are byte addresses on the plain register port
package dgp_pkg;

  // Register offsets
  localparam logic [7:0] OFF_PA_DATA = 8'h05;
  localparam logic [7:0] OFF_PB_DATA = 8'h06;
  localparam logic [7:0] OFF_INTC = 8'h0b;
  localparam logic [7:0] OFF_OPTION = 8'h81;
  localparam logic [7:0] OFF_PA_DIR = 8'h85;
  localparam logic [7:0] OFF_PB_DIR = 8'h86;
  localparam logic [7:0] OFF_PERIPH = 8'h9e;
  localparam logic [7:0] OFF_ANALOG = 8'h9f;

  // Field positions
  localparam int OPT_PU_DIS_N_BIT = 7;
  localparam int OPT_EDGE_BIT = 6;
  localparam int INTC_CHG_BIT = 0;
  localparam int INTC_EXT_BIT = 1;
  localparam int PER_TMR_BIT = 0;
  localparam int PER_SS_BIT = 1;
  localparam int PA_TMR_PIN = 4;
  localparam int PA_SS_PIN = 5;

  // Reset values
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] PB_DIR_RST = 8'hff;
  localparam logic [5:0] PA_DIR_RST = 6'h3f;
  localparam logic [7:0] PB_LAT_POR = 8'h00;
  localparam logic [5:0] PA_LAT_POR = 6'h00;
  localparam logic [3:0] ANALOG_RST = 4'hf;
  localparam logic [1:0] PERIPH_RST = 2'h0;
  localparam logic [7:0] ZERO8 = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic wr;
    logic rd;
  } dgp_bus_req_t;

  typedef struct packed {
    logic [5:0] pa_lat;
    logic [5:0] pa_dir;
    logic [7:0] pb_lat;
    logic [7:0] pb_dir;
    logic [7:0] option;
    logic [3:0] analog;
    logic [1:0] periph;
    logic chg_flag;
    logic ext_flag;
    logic [3:0] cmp;
    logic [5:0] pa_s1;
    logic [5:0] pa_s2;
    logic [7:0] pb_s1;
    logic [7:0] pb_s2;
    logic pb0_prev;
    logic [7:0] rd_data;
    logic [5:0] pa_out;
    logic [5:0] pa_oe_n;
    logic [7:0] pb_out;
    logic [7:0] pb_oe_n;
    logic [7:0] pb_pu;
    logic wake;
  } dgp_state_t;

endpackage

// [verilog/dgp_gpio.sv]
// Purpose: two general purpose ports, pull-ups on the second port, edge interrupt and change detection
// Assumes: i_rst synchronous active high, i_por high with it on power-on reset
// Notes:   pin drivers and read data are registered, so they lag their source by one cycle
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module dgp_gpio (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_por,
  input wire dgp_pkg::dgp_bus_req_t i_bus,
  output logic [7:0] o_rd_data,
  input wire logic [5:0] i_pa_pin,
  output logic [5:0] o_pa_out,
  output logic [5:0] o_pa_oe_n,
  input wire logic [7:0] i_pb_pin,
  output logic [7:0] o_pb_out,
  output logic [7:0] o_pb_oe_n,
  output logic [7:0] o_pb_pullup,
  output logic o_timer_clk,
  output logic o_slave_sel_n,
  output logic o_change_flag,
  output logic o_ext_irq_flag,
  input wire logic i_sleep,
  output logic o_wake
);
  import dgp_pkg::*;

  dgp_state_t st_r;
  dgp_state_t st_nxt;
  logic [5:0] pa_read;
  logic [7:0] pb_read;
  logic [3:0] mismatch;
  logic pb_access;
  logic ext_hit;
  logic clr_chg;
  logic clr_ext;
  logic [5:0] pa_dir_eff;

  function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] mask);
    merge8 = (old_v & ~mask) | (new_v & mask);
  endfunction

  // Pins in analog use read as zero; the synchronised copy is what software sees
  assign pa_read = st_r.pa_s2 & ~{2'b00, st_r.analog};
  assign pb_read = st_r.pb_s2;
  // Outputs are excluded from compare by the direction mask
  assign mismatch = (st_r.pb_s2[7:4] ^ st_r.cmp) & st_r.pb_dir[7:4];
  assign pb_access = (i_bus.wr | i_bus.rd) && (i_bus.addr == OFF_PB_DATA);
  assign ext_hit = st_r.option[OPT_EDGE_BIT] ? (st_r.pb_s2[0] & ~st_r.pb0_prev)
                                             : (~st_r.pb_s2[0] & st_r.pb0_prev);
  assign clr_chg = i_bus.wr && (i_bus.addr == OFF_INTC) && i_bus.wmask[INTC_CHG_BIT]
                   && !i_bus.wdata[INTC_CHG_BIT];
  assign clr_ext = i_bus.wr && (i_bus.addr == OFF_INTC) && i_bus.wmask[INTC_EXT_BIT]
                   && !i_bus.wdata[INTC_EXT_BIT];
  // An enabled peripheral forces its pin to input
  assign pa_dir_eff = st_r.pa_dir | {st_r.periph[PER_SS_BIT], st_r.periph[PER_TMR_BIT],
                                     4'h0};

  always_comb begin
    st_nxt = st_r;
    // Two-stage synchronisers on every pin
    st_nxt.pa_s1 = i_pa_pin;
    st_nxt.pa_s2 = st_r.pa_s1;
    st_nxt.pb_s1 = i_pb_pin;
    st_nxt.pb_s2 = st_r.pb_s1;
    st_nxt.pb0_prev = st_r.pb_s2[0];

    // Hardware set wins over a software clear in the same cycle
    st_nxt.chg_flag = (st_r.chg_flag & ~clr_chg) | (|mismatch);
    st_nxt.ext_flag = (st_r.ext_flag & ~clr_ext) | ext_hit;
    st_nxt.wake = i_sleep & (|mismatch);

    if (pb_access) begin
      st_nxt.cmp = st_r.pb_s2[7:4];
    end

    if (i_bus.wr) begin
      unique case (i_bus.addr)
        OFF_PA_DATA: st_nxt.pa_lat = 6'(merge8({2'b00, pa_read}, i_bus.wdata,
                                               i_bus.wmask));
        OFF_PB_DATA: st_nxt.pb_lat = merge8(pb_read, i_bus.wdata, i_bus.wmask);
        OFF_PA_DIR: st_nxt.pa_dir = 6'(merge8({2'b00, st_r.pa_dir}, i_bus.wdata,
                                              i_bus.wmask));
        OFF_PB_DIR: st_nxt.pb_dir = merge8(st_r.pb_dir, i_bus.wdata, i_bus.wmask);
        OFF_OPTION: st_nxt.option = merge8(st_r.option, i_bus.wdata, i_bus.wmask);
        OFF_PERIPH: st_nxt.periph = 2'(merge8({6'h00, st_r.periph}, i_bus.wdata,
                                              i_bus.wmask));
        OFF_ANALOG: st_nxt.analog = 4'(merge8({4'h0, st_r.analog}, i_bus.wdata,
                                              i_bus.wmask));
        default: ;
      endcase
    end

    // Read data stands only in the cycle after the strobe
    st_nxt.rd_data = ZERO8;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        OFF_PA_DATA: st_nxt.rd_data = {2'b00, pa_read};
        OFF_PB_DATA: st_nxt.rd_data = pb_read;
        OFF_INTC: st_nxt.rd_data = {6'h00, st_r.ext_flag, st_r.chg_flag};
        OFF_OPTION: st_nxt.rd_data = st_r.option;
        OFF_PA_DIR: st_nxt.rd_data = {2'b00, st_r.pa_dir};
        OFF_PB_DIR: st_nxt.rd_data = st_r.pb_dir;
        OFF_PERIPH: st_nxt.rd_data = {6'h00, st_r.periph};
        OFF_ANALOG: st_nxt.rd_data = {4'h0, st_r.analog};
        default: st_nxt.rd_data = ZERO8;
      endcase
    end

    // Pin drive; pin 4 only ever pulls low
    st_nxt.pa_out = st_r.pa_lat & ~6'h10;
    st_nxt.pa_oe_n = pa_dir_eff;
    st_nxt.pa_oe_n[PA_TMR_PIN] = pa_dir_eff[PA_TMR_PIN] | st_r.pa_lat[PA_TMR_PIN];
    st_nxt.pb_out = st_r.pb_lat;
    st_nxt.pb_oe_n = st_r.pb_dir;
    st_nxt.pb_pu = st_r.pb_dir & {8{~st_r.option[OPT_PU_DIS_N_BIT]}};

    if (i_rst) begin
      st_nxt.pb_dir = PB_DIR_RST;
      st_nxt.option = OPTION_RST;
      st_nxt.pa_dir = PA_DIR_RST;
      st_nxt.periph = PERIPH_RST;
      st_nxt.chg_flag = 1'b0;
      st_nxt.ext_flag = 1'b0;
      st_nxt.cmp = 4'h0;
      st_nxt.pa_s1 = 6'h00;
      st_nxt.pa_s2 = 6'h00;
      st_nxt.pb_s1 = ZERO8;
      st_nxt.pb_s2 = ZERO8;
      st_nxt.pb0_prev = 1'b0;
      st_nxt.rd_data = ZERO8;
      st_nxt.pa_out = 6'h00;
      st_nxt.pa_oe_n = 6'h3f;
      st_nxt.pb_out = ZERO8;
      st_nxt.pb_oe_n = 8'hff;
      st_nxt.pb_pu = ZERO8;
      st_nxt.wake = 1'b0;
      // Latches survive a warm reset; only power-on clears them
      if (i_por) begin
        st_nxt.pb_lat = PB_LAT_POR;
        st_nxt.pa_lat = PA_LAT_POR;
        st_nxt.analog = ANALOG_RST;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st_r <= st_nxt;
  end

  assign o_rd_data = st_r.rd_data;
  assign o_pa_out = st_r.pa_out;
  assign o_pa_oe_n = st_r.pa_oe_n;
  assign o_pb_out = st_r.pb_out;
  assign o_pb_oe_n = st_r.pb_oe_n;
  assign o_pb_pullup = st_r.pb_pu;
  assign o_timer_clk = st_r.pa_s2[PA_TMR_PIN];
  assign o_slave_sel_n = st_r.pa_s2[PA_SS_PIN];
  assign o_change_flag = st_r.chg_flag;
  assign o_ext_irq_flag = st_r.ext_flag;
  assign o_wake = st_r.wake;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  pb_drive_dir_a: assert property (
    ##1 o_pb_oe_n == $past(st_r.pb_dir))
    else $error("second port enables do not follow direction");

  pullup_out_off_a: assert property (
    (o_pb_pullup & ~o_pb_oe_n) == ZERO8)
    else $error("pull-up on while pin drives");

  pullup_reset_a: assert property (
    $past(i_rst) |-> o_pb_pullup == ZERO8 && st_r.option == OPTION_RST)
    else $error("pull-up on right after reset");

  change_set_a: assert property (
    (|mismatch) |=> o_change_flag)
    else $error("mismatch did not set change flag");

  change_cause_a: assert property (
    $rose(o_change_flag) |-> $past(|((st_r.pb_s2[7:4] ^ st_r.cmp) & st_r.pb_dir[7:4])))
    else $error("change flag rose without an input mismatch");

  compare_reload_a: assert property (
    pb_access |=> st_r.cmp == $past(st_r.pb_s2[7:4]))
    else $error("port access did not reload compare");

  open_drain_a: assert property (
    (o_pa_out[PA_TMR_PIN] == 1'b0) and
    (!o_pa_oe_n[PA_TMR_PIN] |-> !$past(st_r.pa_lat[PA_TMR_PIN])))
    else $error("timer pin drove high");

  analog_read_a: assert property (
    (i_bus.rd && i_bus.addr == OFF_PA_DATA && st_r.analog == ANALOG_RST)
      |=> o_rd_data[3:0] == 4'h0)
    else $error("analog pin read nonzero");

  rmw_write_a: assert property (
    (i_bus.wr && i_bus.addr == OFF_PB_DATA)
      |=> st_r.pb_lat == (($past(pb_read) & ~$past(i_bus.wmask))
                         | ($past(i_bus.wdata) & $past(i_bus.wmask))))
    else $error("second port write not read-modify-write");

  ext_edge_a: assert property (
    (st_r.option[OPT_EDGE_BIT] && st_r.pb_s2[0] && !st_r.pb0_prev) |=> o_ext_irq_flag)
    else $error("selected edge missed external flag");

  wake_a: assert property (
    (i_sleep && (|mismatch)) |=> o_wake)
    else $error("change did not wake");

endmodule // dgp_gpio

// [test/dgp_pins_model.sv]
// Purpose: board side of both ports, resolving each pin level
// Assumes: the design drives a pin while its output enable is low
// Notes:   a floating pin without pull-up toggles, so no stale level is read
`timescale 1ns/100ps
module dgp_pins_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_pb_out,
  input wire logic [7:0] i_pb_oe_n,
  input wire logic [7:0] i_pb_pullup,
  input wire logic [7:0] i_pb_ext,
  input wire logic [7:0] i_pb_ext_en,
  input wire logic [5:0] i_pa_out,
  input wire logic [5:0] i_pa_oe_n,
  input wire logic [5:0] i_pa_ext,
  output logic [7:0] o_pb_pin,
  output logic [5:0] o_pa_pin
);
  logic [7:0] pb_last_r;
  always_ff @(posedge i_clk_sys) begin
    pb_last_r <= o_pb_pin;
  end
  // Driver wins, then the board, then the weak pull-up
  assign o_pb_pin = (~i_pb_oe_n & i_pb_out) | (i_pb_oe_n & ((i_pb_ext_en & i_pb_ext) |
    (~i_pb_ext_en & (i_pb_pullup | ~pb_last_r))));
  assign o_pa_pin = (i_pa_oe_n & i_pa_ext) | (~i_pa_oe_n & i_pa_out);
endmodule // dgp_pins_model

// [test/dgp_gpio_tb.sv]
// Purpose: self-checking bench for the dual GPIO port block
// Assumes: pins resolved by dgp_pins_model
// Notes:   flags are awaited under a bounded count
`timescale 1ns/100ps
module dgp_gpio_tb;
  import dgp_pkg::*;
  logic i_clk_sys = 0, i_rst = 1, i_por = 1, i_sleep = 0;
  dgp_bus_req_t bus = '0;
  logic [7:0] rdd, pb_out, pb_oe_n, pb_pu, pb_pin, pb_ext = 8'h30, pb_en = 8'hfd;
  logic [5:0] pa_out, pa_oe_n, pa_pin, pa_ext = 6'h3f;
  logic tclk, ssn, chg, ext, wake;
  int num_errors = 0, comparisons = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  dgp_gpio i_dgp_gpio (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_por(i_por), .i_bus(bus),
    .o_rd_data(rdd), .i_pa_pin(pa_pin), .o_pa_out(pa_out), .o_pa_oe_n(pa_oe_n),
    .i_pb_pin(pb_pin), .o_pb_out(pb_out), .o_pb_oe_n(pb_oe_n), .o_pb_pullup(pb_pu),
    .o_timer_clk(tclk), .o_slave_sel_n(ssn), .o_change_flag(chg), .o_ext_irq_flag(ext),
    .i_sleep(i_sleep), .o_wake(wake));
  dgp_pins_model i_dgp_pins_model (.i_clk_sys(i_clk_sys), .i_pb_out(pb_out),
    .i_pb_oe_n(pb_oe_n), .i_pb_pullup(pb_pu), .i_pb_ext(pb_ext), .i_pb_ext_en(pb_en),
    .i_pa_out(pa_out), .i_pa_oe_n(pa_oe_n), .i_pa_ext(pa_ext), .o_pb_pin(pb_pin),
    .o_pa_pin(pa_pin));
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [7:0] m = 8'hff);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: d, wmask: m, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wmask: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    bus.rd <= 1'b0;
    #1 chk("read data", rdd, e);
  endtask
  // Stops early only when waiting for a flag to rise
  task automatic await(string n, int s, logic e);
    logic v;
    for (int i = 0; i < 8; i++) begin
      idle(1);
      v = s == 0 ? chg : s == 1 ? ext : wake;
      if (v === e && e) break;
    end
    chk(n, {7'h0, v}, {7'h0, e});
  endtask
  task automatic reset(logic p);
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    i_por <= p;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    i_por <= 1'b0;
    idle(3);
  endtask
  initial begin
    reset(1'b1);
    chk("pb oe_n", pb_oe_n, 8'hff);
    chk("pullup", pb_pu, 8'h00);
    chk("shared pins", {6'h0, ssn, tclk}, 8'h03);
    rd(OFF_OPTION, 8'hff);
    rd(OFF_PB_DIR, 8'hff);
    rd(8'h40, 8'h00);
    rd(OFF_PA_DATA, 8'h30);
    $display("test reset done");
    wr(OFF_PB_DIR, 8'hf0);
    wr(OFF_PB_DATA, 8'ha5);
    idle(3);
    chk("pb oe_n", pb_oe_n, 8'hf0);
    chk("pb out", pb_out, 8'ha5);
    rd(OFF_PB_DATA, 8'h35);
    wr(OFF_OPTION, 8'h7f);
    idle(2);
    chk("pullup", pb_pu, 8'hf0);
    wr(OFF_PB_DATA, 8'h00, 8'h01);
    wr(OFF_PB_DIR, 8'h00);
    idle(2);
    chk("pb out", pb_out, 8'h34);
    wr(OFF_PA_DIR, 8'h00);
    wr(OFF_PA_DATA, 8'h3f);
    idle(2);
    chk("pa out", {2'h0, pa_out}, 8'h2f);
    wr(OFF_PERIPH, 8'h02);
    idle(2);
    chk("pa oe_n", {7'h0, pa_oe_n[5]}, 8'h01);
    $display("test drive done");
    wr(OFF_PB_DIR, 8'h7f);
    idle(4);
    rd(OFF_PB_DATA, 8'h32);
    wr(OFF_INTC, 8'h00, 8'h03);
    @(posedge i_clk_sys) pb_ext <= 8'hb0;
    await("change flag", 0, 1'b0);
    @(posedge i_clk_sys) pb_ext <= 8'hf0;
    await("change flag", 0, 1'b1);
    wr(OFF_INTC, 8'h00, 8'h01);
    await("change flag", 0, 1'b1);
    rd(OFF_PB_DATA, 8'h72);
    wr(OFF_INTC, 8'h00, 8'h01);
    await("change flag", 0, 1'b0);
    @(posedge i_clk_sys) i_sleep <= 1'b1;
    @(posedge i_clk_sys) pb_ext <= 8'hd0;
    await("wake", 2, 1'b1);
    @(posedge i_clk_sys) i_sleep <= 1'b0;
    rd(OFF_PB_DATA, 8'h52);
    wr(OFF_INTC, 8'h00, 8'h03);
    $display("test change done");
    @(posedge i_clk_sys) pb_ext <= 8'hd1;
    await("ext flag", 1, 1'b1);
    wr(OFF_INTC, 8'h00, 8'h02);
    @(posedge i_clk_sys) pb_ext <= 8'hd0;
    await("ext flag", 1, 1'b0);
    wr(OFF_OPTION, 8'h3f);
    @(posedge i_clk_sys) pb_ext <= 8'hd1;
    await("ext flag", 1, 1'b0);
    @(posedge i_clk_sys) pb_ext <= 8'hd0;
    await("ext flag", 1, 1'b1);
    $display("test edge done");
    reset(1'b0);
    rd(OFF_OPTION, 8'hff);
    chk("pullup", pb_pu, 8'h00);
    wr(OFF_PB_DIR, 8'h00);
    idle(2);
    chk("pb out", pb_out, 8'h34);
    $display("test warm reset done");
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    num_errors++;
    wrap_up();
  end
endmodule // dgp_gpio_tb
